// >>> fault_side.sv
// Far side model: request pins, timer output levels, clock monitor, comparator
`default_nettype none
module fault_side (
    input wire logic clock,
    output logic [2:0] req_n,
    output logic [5:0] pins,
    output logic osc,
    output logic cmp
);
    timeunit 1ns;
    timeprecision 1ps;
    // Request pins rest high, as their pull-ups would hold them
    initial
    begin
        req_n = 3'h7;
        pins = 6'h00;
        osc = 1'b0;
        cmp = 1'b0;
    end
    // Levels move only just after an edge and hold until the next call
    task automatic put(input logic [2:0] r, input logic [5:0] p, input logic o, input logic c);
        @(posedge clock);
        req_n <= r;
        pins <= p;
        osc <= o;
        cmp <= c;
    endtask
endmodule
`default_nettype wire

// >>> poe_pkg.sv
// Shared constants and types of the output shutdown block
`default_nettype none
package poe_pkg;
    localparam int ADDR_W = 8;
    // Register byte offsets
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] MODE_OFF = 8'h04;
    localparam logic [7:0] LEVEL_OFF = 8'h08;
    localparam logic [7:0] CH0EN_OFF = 8'h0C;
    localparam logic [7:0] STAT_OFF = 8'h10;
    localparam logic [7:0] MASK_OFF = 8'h14;
    localparam logic [7:0] PINS_OFF = 8'h18;
    // Values after reset
    localparam logic CTRL_RST = 1'b0;
    localparam logic [5:0] MODE_RST = 6'h00;
    localparam logic [5:0] LEVEL_RST = 6'h3F;
    localparam logic [7:0] CH0EN_RST = 8'h00;
    localparam logic [5:0] MASK_RST = 6'h00;
    // Status and mask field positions
    localparam int ST_REQ_A = 0;
    localparam int ST_REQ_B = 1;
    localparam int ST_REQ_C = 2;
    localparam int ST_SHORT = 3;
    localparam int ST_OSC = 4;
    localparam int ST_CMP = 5;
    localparam int ST_W = 6;
    // Control field position and field widths
    localparam int CTRL_SOFT = 0;
    localparam int PAIR_PINS = 6;
    localparam int CH0_PINS = 8;
    // Sampling and divider counts
    localparam int SAMPLE_COUNT = 16;
    localparam int DIV_W = 7;
    localparam int SYNC_N = 3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0]
    {
        MODE_EDGE = 2'b00,
        MODE_DIV8 = 2'b01,
        MODE_DIV16 = 2'b10,
        MODE_DIV128 = 2'b11
    } req_mode_t;
endpackage
`default_nettype wire

// >>> poe_tick_if.sv
// Sampling clock enables shared by the request qualifiers
`default_nettype none
interface poe_tick_if;
    logic tick8;
    logic tick16;
    logic tick128;
    modport src (output tick8, output tick16, output tick128);
    modport snk (input tick8, input tick16, input tick128);
endinterface
`default_nettype wire

// >>> pwm_output_shutdown.sv
// Timer output shutdown controller with AXI4-Lite registers
// How it works
// - Each request pin detects a falling edge or 16 low samples at clock/8, /16, /128.
// - A qualified request on any of the three pins puts controlled outputs in high impedance.
// - Controlled pins: eight channel-0 outputs, 3B/3D, and 4A to 4D.
// - Pairs 3B/3D, 4A/4C, 4B/4D are compared; both active together flags a short.
// - A short forces shutdown after three cycles, on the complementary PWM pins only.
// - Each of the six complementary pins has its own active level select bit.
// - Oscillation stop from the clock monitor puts controlled outputs in high impedance.
// - A comparator detection puts controlled outputs in high impedance.
// - A software control bit forces controlled outputs into high impedance directly.
// - Request sampling and output comparison results can raise an interrupt.
// - Every channel-0 pin placement has its own high impedance enable.
//
// Implementation choices: the AXI4-Lite slave port and the register addresses.
`default_nettype none
module pwm_output_shutdown (
    input wire logic clock,
    input wire logic rstn,
    input wire logic [poe_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [poe_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic shutdown_request_in_a_n,
    input wire logic shutdown_request_in_b_n,
    input wire logic shutdown_request_in_c_n,
    input wire logic ch3_output_b,
    input wire logic ch3_output_d,
    input wire logic ch4_output_a,
    input wire logic ch4_output_b,
    input wire logic ch4_output_c,
    input wire logic ch4_output_d,
    input wire logic osc_stop,
    input wire logic analog_comparator,
    output logic [poe_pkg::CH0_PINS-1:0] ch0_hiz,
    output logic [poe_pkg::PAIR_PINS-1:0] pair_hiz,
    output logic irq
);
    import poe_pkg::*;

    logic soft_hiz_r;
    logic [5:0] mode_r;
    logic [PAIR_PINS-1:0] level_sel_r;
    logic [CH0_PINS-1:0] ch0_en_r;
    logic [ST_W-1:0] status_r;
    logic [ST_W-1:0] mask_r;
    logic [ST_W-1:0] status_set;
    logic [ST_W-1:0] status_clr;
    logic [DIV_W-1:0] div_r;
    logic [2:0] req_det;
    logic [PAIR_PINS-1:0] pin_level;
    logic [PAIR_PINS-1:0] pin_active;
    logic [2:0] both_r;
    logic [SYNC_N-1:0] osc_sync_r;
    logic [SYNC_N-1:0] cmp_sync_r;
    logic osc_r;
    logic cmp_r;
    logic all_src;
    logic aw_held_r;
    logic w_held_r;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic wstrb0_q;
    logic do_write;
    logic wr_hit;
    logic [31:0] rd_data;
    logic rd_hit;

    poe_tick_if tick_bus ();

    // Sampling enables from one free-running divider
    always_ff @(posedge clock)
    begin
        if (!rstn)
            div_r <= '0;
        else
            div_r <= div_r + DIV_W'(1);
    end

    assign tick_bus.tick8 = &div_r[2:0];
    assign tick_bus.tick16 = &div_r[3:0];
    assign tick_bus.tick128 = &div_r;

    request_qualifier #(.SAMPLES(SAMPLE_COUNT)) u_req_a (
        .clock(clock),
        .rstn(rstn),
        .req_n(shutdown_request_in_a_n),
        .mode(req_mode_t'(mode_r[1:0])),
        .tick(tick_bus),
        .detect(req_det[0])
    );

    request_qualifier #(.SAMPLES(SAMPLE_COUNT)) u_req_b (
        .clock(clock),
        .rstn(rstn),
        .req_n(shutdown_request_in_b_n),
        .mode(req_mode_t'(mode_r[3:2])),
        .tick(tick_bus),
        .detect(req_det[1])
    );

    request_qualifier #(.SAMPLES(SAMPLE_COUNT)) u_req_c (
        .clock(clock),
        .rstn(rstn),
        .req_n(shutdown_request_in_c_n),
        .mode(req_mode_t'(mode_r[5:4])),
        .tick(tick_bus),
        .detect(req_det[2])
    );

    // Clock monitor and comparator may sit in other domains
    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            osc_sync_r <= '0;
            cmp_sync_r <= '0;
        end
        else
        begin
            osc_sync_r <= {osc_sync_r[SYNC_N-2:0], osc_stop};
            cmp_sync_r <= {cmp_sync_r[SYNC_N-2:0], analog_comparator};
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            osc_r <= 1'b0;
            cmp_r <= 1'b0;
        end
        else
        begin
            if (osc_sync_r[1] == osc_sync_r[2])
                osc_r <= osc_sync_r[1];
            if (cmp_sync_r[1] == cmp_sync_r[2])
                cmp_r <= cmp_sync_r[1];
        end
    end

    // Pair order: 3B/3D, 4A/4C, 4B/4D
    assign pin_level = {ch4_output_d, ch4_output_b, ch4_output_c, ch4_output_a,
        ch3_output_d, ch3_output_b};
    assign pin_active = ~(pin_level ^ level_sel_r);

    // Registering the overlap delays it one cycle; an overlap seen at a single edge still counts
    genvar p;
    generate
        for (p = 0; p < 3; p++)
        begin : g_pair
            always_ff @(posedge clock)
            begin
                if (!rstn)
                    both_r[p] <= 1'b0;
                else
                    both_r[p] <= pin_active[2*p] & pin_active[2*p+1];
            end
        end
    endgenerate

    always_comb
    begin
        status_set = '0;
        status_set[ST_REQ_C:ST_REQ_A] = req_det;
        status_set[ST_SHORT] = |both_r;
        status_set[ST_OSC] = osc_r;
        status_set[ST_CMP] = cmp_r;
    end

    // A write with lane 0 off must leave the flags alone, as for every other register
    assign status_clr = (do_write && wr_hit && wstrb0_q && awaddr_q == STAT_OFF) ?
        wdata_q[ST_W-1:0] : '0;

    // Set beats clear, so a flag cannot drop while its cause persists
    always_ff @(posedge clock)
    begin
        if (!rstn)
            status_r <= '0;
        else
            status_r <= (status_r & ~status_clr) | status_set;
    end

    assign all_src = |status_r[ST_REQ_C:ST_REQ_A] | status_r[ST_OSC] | status_r[ST_CMP]
        | soft_hiz_r;

    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            ch0_hiz <= '0;
            pair_hiz <= '0;
        end
        else
        begin
            ch0_hiz <= {CH0_PINS{all_src}} & ch0_en_r;
            pair_hiz <= {PAIR_PINS{all_src | status_r[ST_SHORT]}};
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rstn)
            irq <= 1'b0;
        else
            irq <= |(status_r & mask_r);
    end

    // Write channel: address and data taken in either order
    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            aw_held_r <= 1'b0;
            s_axi_awready <= 1'b1;
            awaddr_q <= '0;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_held_r <= 1'b1;
            s_axi_awready <= 1'b0;
            awaddr_q <= s_axi_awaddr;
        end
        else if (s_axi_bvalid && s_axi_bready)
        begin
            aw_held_r <= 1'b0;
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            w_held_r <= 1'b0;
            s_axi_wready <= 1'b1;
            wdata_q <= '0;
            wstrb0_q <= 1'b0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_held_r <= 1'b1;
            s_axi_wready <= 1'b0;
            wdata_q <= s_axi_wdata;
            wstrb0_q <= s_axi_wstrb[0];
        end
        else if (s_axi_bvalid && s_axi_bready)
        begin
            w_held_r <= 1'b0;
            s_axi_wready <= 1'b1;
        end
    end

    assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;
    assign wr_hit = awaddr_q == CTRL_OFF || awaddr_q == MODE_OFF || awaddr_q == LEVEL_OFF
        || awaddr_q == CH0EN_OFF || awaddr_q == STAT_OFF || awaddr_q == MASK_OFF
        || awaddr_q == PINS_OFF;

    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end
        else if (do_write)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // All fields sit in byte lane 0
    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            soft_hiz_r <= CTRL_RST;
            mode_r <= MODE_RST;
            level_sel_r <= LEVEL_RST;
            ch0_en_r <= CH0EN_RST;
            mask_r <= MASK_RST;
        end
        else if (do_write && wstrb0_q)
        begin
            case (awaddr_q)
                CTRL_OFF: soft_hiz_r <= wdata_q[CTRL_SOFT];
                MODE_OFF: mode_r <= wdata_q[5:0];
                LEVEL_OFF: level_sel_r <= wdata_q[PAIR_PINS-1:0];
                CH0EN_OFF: ch0_en_r <= wdata_q[CH0_PINS-1:0];
                MASK_OFF: mask_r <= wdata_q[ST_W-1:0];
                default: ;
            endcase
        end
    end

    // Read channel
    always_comb
    begin
        rd_data = '0;
        rd_hit = 1'b1;
        case (s_axi_araddr)
            CTRL_OFF: rd_data[CTRL_SOFT] = soft_hiz_r;
            MODE_OFF: rd_data[5:0] = mode_r;
            LEVEL_OFF: rd_data[PAIR_PINS-1:0] = level_sel_r;
            CH0EN_OFF: rd_data[CH0_PINS-1:0] = ch0_en_r;
            STAT_OFF: rd_data[ST_W-1:0] = status_r;
            MASK_OFF: rd_data[ST_W-1:0] = mask_r;
            PINS_OFF: rd_data[PAIR_PINS-1:0] = pin_level;
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_data;
            s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// >>> pwm_output_shutdown_asserts.sv
// Port-level assertions of the output shutdown controller
`default_nettype none
module shutdown_checker (
    input wire logic clock,
    input wire logic rstn,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic shutdown_request_in_a_n,
    input wire logic ch4_output_a,
    input wire logic ch4_output_c,
    input wire logic osc_stop,
    input wire logic analog_comparator,
    input wire logic [poe_pkg::CH0_PINS-1:0] ch0_hiz,
    input wire logic [poe_pkg::PAIR_PINS-1:0] pair_hiz,
    input wire logic irq
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    // Counts low cycles of pin a; longer than 16 samples at clock/128
    logic [11:0] low_cnt_r;
    always_ff @(posedge clock)
    begin
        if (!rstn || shutdown_request_in_a_n)
            low_cnt_r <= 12'h000;
        else if (low_cnt_r != 12'hFFF)
            low_cnt_r <= low_cnt_r + 12'h001;
    end
    sequence both_on;
        ch4_output_a && ch4_output_c;
    endsequence
    sequence hiz_all;
        pair_hiz == 6'h3F;
    endsequence
    wr_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write channels open during response");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    req_hiz_a: assert property (low_cnt_r == 12'h834 |-> hiz_all)
        else $error("long request without high impedance");
    short_hiz_a: assert property (both_on |-> ##3 hiz_all)
        else $error("short not acted on");
    osc_hiz_a: assert property (osc_stop |-> ##[1:8] hiz_all)
        else $error("oscillation stop not acted on");
    cmp_hiz_a: assert property (analog_comparator |-> ##[1:8] hiz_all)
        else $error("comparator event not acted on");
    ch0_gate_a: assert property ((ch0_hiz != 8'h00) |-> hiz_all)
        else $error("channel 0 off while pairs drive");
    hiz_hold_a: assert property ($fell(pair_hiz[0]) |->
        $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
        else $error("high impedance left without software clear");
    irq_cause_a: assert property (irq |-> pair_hiz != 6'h00)
        else $error("interrupt without shutdown cause");
endmodule
bind pwm_output_shutdown shutdown_checker checker_i (.clock, .rstn, .s_axi_awready,
    .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .shutdown_request_in_a_n, .ch4_output_a, .ch4_output_c, .osc_stop,
    .analog_comparator, .ch0_hiz, .pair_hiz, .irq);
`default_nettype wire

// >>> request_qualifier.sv
// Qualifier for one active-low shutdown request pin
`default_nettype none
module request_qualifier #(
    parameter int SAMPLES = poe_pkg::SAMPLE_COUNT
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic req_n,
    input wire poe_pkg::req_mode_t mode,
    poe_tick_if.snk tick,
    output logic detect
);
    import poe_pkg::*;
    localparam int CW = $clog2(SAMPLES + 1);
    localparam logic [CW-1:0] FULL = CW'(SAMPLES);
    logic [SYNC_N-1:0] sync_r;
    logic level_r;
    logic prev_r;
    logic [CW-1:0] cnt_r;
    logic tick_sel;

    always_ff @(posedge clock)
    begin
        if (!rstn)
            sync_r <= '1;
        else
            sync_r <= {sync_r[SYNC_N-2:0], req_n};
    end

    // A change counts only once the second and third stages agree
    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            level_r <= 1'b1;
            prev_r <= 1'b1;
        end
        else
        begin
            if (sync_r[1] == sync_r[2])
                level_r <= sync_r[1];
            prev_r <= level_r;
        end
    end

    always_comb
    begin
        case (mode)
            MODE_DIV8: tick_sel = tick.tick8;
            MODE_DIV16: tick_sel = tick.tick16;
            MODE_DIV128: tick_sel = tick.tick128;
            default: tick_sel = 1'b0;
        endcase
    end

    // Any high sample restarts the run of low samples
    always_ff @(posedge clock)
    begin
        if (!rstn || level_r)
            cnt_r <= '0;
        else if (tick_sel && cnt_r != FULL)
            cnt_r <= cnt_r + CW'(1);
    end

    always_ff @(posedge clock)
    begin
        if (!rstn)
            detect <= 1'b0;
        else if (mode == MODE_EDGE)
            detect <= prev_r & ~level_r;
        else
            detect <= (cnt_r == FULL);
    end
endmodule
`default_nettype wire

// >>> tb_pwm_output_shutdown.sv
// Self-checking bench of the output shutdown controller
`default_nettype none
module tb_pwm_output_shutdown;
    timeunit 1ns;
    timeprecision 1ps;
    import poe_pkg::*;
    localparam logic [1:0] ok = RESP_OKAY;
    logic clock, rstn, osc_stop, analog_comparator, irq;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr, ch0_hiz, en;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [5:0] pair_hiz, pins, lv, p, m;
    logic [2:0] req_n;
    int err_total = 0, checked = 0, seed = 42, dv;
    wire logic shutdown_request_in_a_n = req_n[0];
    wire logic shutdown_request_in_b_n = req_n[1];
    wire logic shutdown_request_in_c_n = req_n[2];
    wire logic ch3_output_b = pins[0];
    wire logic ch3_output_d = pins[1];
    wire logic ch4_output_a = pins[2];
    wire logic ch4_output_c = pins[3];
    wire logic ch4_output_b = pins[4];
    wire logic ch4_output_d = pins[5];
    pwm_output_shutdown pwm_output_shutdown_i (.*);
    fault_side fault_side_i (.clock, .req_n, .pins, .osc(osc_stop), .cmp(analog_comparator));
    initial
    begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        checked++;
        if (s !== e)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        bit ad, wd;
        ad = 0;
        wd = 0;
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(ad && wd))
        begin
            @(posedge clock);
            ad |= s_axi_awready & s_axi_awvalid;
            wd |= s_axi_wready & s_axi_wvalid;
            s_axi_awvalid <= !ad;
            s_axi_wvalid <= !wd;
        end
        while (!s_axi_bvalid)
            @(posedge clock);
        s_axi_bready <= 1'b0;
        chk("bresp", er, s_axi_bresp);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
            @(posedge clock);
        while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        while (!s_axi_rvalid)
            @(posedge clock);
        s_axi_rready <= 1'b0;
        chk("rdata", e, s_axi_rdata);
        chk("rresp", er, s_axi_rresp);
    endtask
    // A pair shorts when both its pins sit at their selected active level
    function automatic logic shorted(input logic [5:0] l, input logic [5:0] q);
        logic [5:0] on;
        on = ~(q ^ l);
        return (on[0] & on[1]) | (on[2] & on[3]) | (on[4] & on[5]);
    endfunction
    initial
    begin
        #800000;
        err_total++;
        $display("[FAIL] watchdog expected finish seen hang");
        give_verdict();
    end
    initial
    begin
        rstn = 1'b0;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0;
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        chk("reset hiz", 32'h0, {ch0_hiz, pair_hiz});
        rd(CTRL_OFF, CTRL_RST, ok);
        rd(MODE_OFF, MODE_RST, ok);
        rd(LEVEL_OFF, LEVEL_RST, ok);
        rd(CH0EN_OFF, CH0EN_RST, ok);
        rd(MASK_OFF, MASK_RST, ok);
        wr(8'h1C, 32'h1, RESP_SLVERR);
        rd(8'h1C, 32'h0, RESP_SLVERR);
        wr(PINS_OFF, 32'h3F, ok);
        rd(PINS_OFF, 32'h0, ok);
        s_axi_wstrb <= 4'h0;
        wr(MASK_OFF, 32'h3F, ok);
        s_axi_wstrb <= 4'hF;
        rd(MASK_OFF, MASK_RST, ok);
        $display("register test done");
        en = 8'($random(seed));
        wr(CH0EN_OFF, 32'(en), ok);
        wr(CTRL_OFF, 32'h1, ok);
        wt(3);
        chk("soft hiz", {en, 6'h3F}, {ch0_hiz, pair_hiz});
        wr(CTRL_OFF, 32'h0, ok);
        wt(3);
        chk("soft off", 32'h0, {ch0_hiz, pair_hiz});
        $display("software test done");
        for (int i = 0; i < 3; i++)
        begin
            m = 6'($random(seed));
            wr(MASK_OFF, 32'(m), ok);
            fault_side_i.put(~(3'h1 << i), 6'h00, 1'b0, 1'b0);
            wt(10);
            fault_side_i.put(3'h7, 6'h00, 1'b0, 1'b0);
            rd(STAT_OFF, 32'h1 << i, ok);
            chk("req hiz", {en, 6'h3F}, {ch0_hiz, pair_hiz});
            chk("req irq", m[i], irq);
            wr(STAT_OFF, 32'h3F, ok);
            wt(3);
            chk("req clear", 32'h0, {irq, ch0_hiz, pair_hiz});
        end
        $display("edge request test done");
        for (int md = 1; md < 4; md++)
        begin
            dv = (md == 3) ? 128 : 8 * md;
            wr(MODE_OFF, 32'(md), ok);
            fault_side_i.put(3'h6, 6'h00, 1'b0, 1'b0);
            wt(15 * dv - 8);
            chk("early", 32'h0, pair_hiz);
            wt(dv + 64);
            chk("late", 32'h3F, pair_hiz);
            fault_side_i.put(3'h7, 6'h00, 1'b0, 1'b0);
            wt(8);
            wr(STAT_OFF, 32'h3F, ok);
            wt(3);
            chk("sample clear", 32'h0, pair_hiz);
        end
        $display("sampled request test done");
        for (int k = 0; k < 2; k++)
        begin
            fault_side_i.put(3'h7, 6'h00, k == 0, k == 1);
            wt(8);
            wr(STAT_OFF, 32'h3F, ok);
            rd(STAT_OFF, 32'h10 << k, ok);
            chk("hold hiz", {en, 6'h3F}, {ch0_hiz, pair_hiz});
            fault_side_i.put(3'h7, 6'h00, 1'b0, 1'b0);
            wt(8);
            wr(STAT_OFF, 32'h3F, ok);
            wt(3);
            chk("cause clear", 32'h0, {ch0_hiz, pair_hiz});
        end
        $display("monitor test done");
        wr(MASK_OFF, 32'h3F, ok);
        for (int i = 0; i < 6; i++)
        begin
            lv = {2'($random(seed)), 2'b11, 2'($random(seed))};
            p = 6'($random(seed));
            if (i < 3)
                p = ~lv ^ (6'h03 << (2 * i));
            fault_side_i.put(3'h7, ~lv, 1'b0, 1'b0);
            wr(LEVEL_OFF, 32'(lv), ok);
            wt(4);
            wr(STAT_OFF, 32'h3F, ok);
            wt(3);
            fault_side_i.put(3'h7, p, 1'b0, 1'b0);
            wt(6);
            rd(PINS_OFF, 32'(p), ok);
            rd(STAT_OFF, 32'(shorted(lv, p)) << ST_SHORT, ok);
            chk("short hiz", {8'h00, {6{shorted(lv, p)}}}, {ch0_hiz, pair_hiz});
            chk("short irq", 32'(shorted(lv, p)), irq);
        end
        $display("short test done");
        give_verdict();
    end
endmodule
`default_nettype wire
